/* File: core/mirq_prio_pick.v */
// lowest-index picker over a request vector
module mirq_prio_pick #(
    parameter N = 14
) (
    input  wire [N-1:0] req,
    output reg          found,
    output reg  [3:0]   idx
);

    integer i;

    // ------------------------------------------------------------------------
    // lowest number wins
    // ------------------------------------------------------------------------
    always @* begin
        found = 1'b0;
        idx   = 4'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin // [RULE5]
                found = 1'b1;
                idx   = i[3:0];
            end
        end
    end

endmodule // mirq_prio_pick

/* File: core/mirq_top.v */
// interrupt controller: sources, enables, priority, nesting, vectors, apb registers
//
// Local design decision: the APB slave port.
`include "mirq_defines.vh"

module mirq_top #(
    parameter PINS = 7
) (
    input  wire            mclk,
    input  wire            srst,
    // apb slave
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [9:0]      paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    // request sources
    input  wire            ext_line_zero,
    input  wire            led_card_req,
    input  wire            timer_zero_req,
    input  wire            ext_line_one,
    input  wire            timer_one_req,
    input  wire            serial_zero_req,
    input  wire            timer_two_req,
    input  wire            spi_port_req,
    input  wire            timer_three_req,
    input  wire            usb_link_req,
    input  wire            converter_req,
    input  wire            serial_one_req,
    input  wire            watchdog_req,
    input  wire [PINS-1:0] gpio_pins,
    // cpu core side
    input  wire            core_ack,
    input  wire            core_reti,
    output reg             core_irq_req,
    output reg  [15:0]     core_vec_addr,
    output reg  [3:0]      core_vec_num,
    // summary interrupt
    output reg             irq_out
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function [15:0] vec_addr;
        input [3:0] num;
        begin
            vec_addr = `MIRQ_VEC_BASE + {9'h000, num, 3'b000};
        end
    endfunction

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [7:0]  basic_irq_enable;
    reg  [5:0]  basic_prio_sel;
    reg  [7:0]  pin_irq_enable;
    reg  [7:0]  extended_irq_enable;
    reg  [6:0]  ext_prio_sel;
    reg         led_card_output_select;
    reg  [`MIRQ_STAT_BITS-1:0] event_status;
    reg  [`MIRQ_STAT_BITS-1:0] event_mask;
    reg         high_prio_running;
    reg         low_prio_running;
    reg         pin_prev;
    reg         pin_edge_flag;
    reg         req_is_high;

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    wire [7:0]  reg_idx   = paddr[9:2];
    wire        acc_done  = psel & penable & pready;
    // misaligned accesses are refused and must not write
    wire        wr_stb    = acc_done & pwrite & (paddr[1:0] == 2'b00);
    wire        rd_stb    = acc_done & ~pwrite;
    wire [7:0]  wbyte     = pwdata[7:0];
    reg         addr_hit;
    reg  [7:0]  rd_mux;

    wire        global_irq_allow = basic_irq_enable[`MIRQ_GLB_ALLOW];
    wire        global_irq_block = basic_irq_enable[`MIRQ_GLB_BLOCK];
    wire        nesting_depth_flag = high_prio_running ^ low_prio_running; // [RULE14]

    always @* begin
        addr_hit = (paddr[1:0] == 2'b00);
        rd_mux   = 8'h00;
        case (reg_idx)
            `MIRQ_IDX_BIE:  rd_mux = basic_irq_enable;
            `MIRQ_IDX_BPRI: rd_mux = {high_prio_running, low_prio_running, basic_prio_sel}; // [RULE13]
            `MIRQ_IDX_PIE:  rd_mux = pin_irq_enable;
            `MIRQ_IDX_XIE:  rd_mux = extended_irq_enable & `MIRQ_XIE_WMASK; // [RULE10]
            `MIRQ_IDX_XPRI: rd_mux = {nesting_depth_flag, ext_prio_sel}; // [RULE14]
            `MIRQ_IDX_CTRL: rd_mux = {7'h00, led_card_output_select};
            `MIRQ_IDX_STAT: rd_mux = {{(8-`MIRQ_STAT_BITS){1'b0}}, event_status};
            `MIRQ_IDX_MASK: rd_mux = {{(8-`MIRQ_STAT_BITS){1'b0}}, event_mask};
            default:        addr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // apb answer: ready on the second access cycle
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            // ~pready keeps the answer a single pulse
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_hit;
            if (psel & penable & ~pready & ~pwrite & addr_hit) begin
                prdata <= {24'h000000, rd_mux};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // control register writes
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            basic_irq_enable       <= `MIRQ_RST_REG; // [RULE11]
            basic_prio_sel         <= 6'h00; // [RULE11]
            pin_irq_enable         <= `MIRQ_RST_REG; // [RULE11]
            extended_irq_enable    <= `MIRQ_RST_REG; // [RULE11]
            ext_prio_sel           <= 7'h00; // [RULE11]
            led_card_output_select <= 1'b0;
            event_mask             <= {`MIRQ_STAT_BITS{1'b0}};
        end else if (wr_stb) begin
            case (reg_idx)
                `MIRQ_IDX_BIE:  basic_irq_enable <= wbyte; // [RULE8]
                `MIRQ_IDX_BPRI: basic_prio_sel <= wbyte[5:0]; // [RULE13]
                `MIRQ_IDX_PIE:  pin_irq_enable <= wbyte;
                `MIRQ_IDX_XIE:  extended_irq_enable <= wbyte & `MIRQ_XIE_WMASK; // [RULE9] [RULE10]
                `MIRQ_IDX_XPRI: ext_prio_sel <= wbyte[6:0];
                `MIRQ_IDX_CTRL: led_card_output_select <= wbyte[`MIRQ_CTRL_LEDSEL];
                `MIRQ_IDX_MASK: event_mask <= wbyte[`MIRQ_STAT_BITS-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // gpio combined request
    // ------------------------------------------------------------------------
    wire pin_active = |(gpio_pins & pin_irq_enable[PINS-1:0]); // [RULE12]
    wire pin_rise   = pin_active & ~pin_prev;
    wire pin_edge_mode = pin_irq_enable[`MIRQ_PIE_EDGE];
    wire pin_req    = pin_edge_mode ? pin_edge_flag : pin_active; // [RULE12]
    wire take       = core_ack & core_irq_req;
    wire take_gpio  = take & (core_vec_num == `MIRQ_NUM_GPIO);

    always @(posedge mclk) begin
        if (srst) begin
            pin_prev      <= 1'b0;
            pin_edge_flag <= 1'b0;
        end else begin
            pin_prev <= pin_active;
            if (pin_edge_mode & pin_rise) begin
                pin_edge_flag <= 1'b1;
            end else if (take_gpio | ~pin_edge_mode) begin
                pin_edge_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // request gathering by interrupt number
    // ------------------------------------------------------------------------
    wire [13:0] src_flag;
    wire [13:0] src_en;
    wire [13:0] src_prio;
    wire        line_zero_src = led_card_output_select ? led_card_req : ext_line_zero; // [RULE4]

    // [RULE1]
    assign src_flag = {watchdog_req, pin_req, 1'b0, serial_one_req, converter_req,
                       usb_link_req, timer_three_req, spi_port_req, timer_two_req,
                       serial_zero_req, timer_one_req, ext_line_one, timer_zero_req,
                       line_zero_src};
    // number 11 carries no source and no enable
    assign src_en   = {extended_irq_enable[7:6], 1'b0, extended_irq_enable[4:0],
                       basic_irq_enable[5:0]}; // [RULE15]
    assign src_prio = {ext_prio_sel[6:5], 1'b0, ext_prio_sel[4:0], basic_prio_sel};

    wire        global_ok = global_irq_allow & ~global_irq_block; // [RULE6]
    wire [13:0] eligible  = src_flag & src_en & {14{global_ok}}; // [RULE15]
    wire [13:0] cand_high = eligible & src_prio;
    wire [13:0] cand_low  = eligible & ~src_prio;

    wire        hi_found;
    wire [3:0]  hi_idx;
    wire        lo_found;
    wire [3:0]  lo_idx;

    mirq_prio_pick #(
        .N (`MIRQ_NUM_COUNT)
    ) u_pick_high (
        .req   (cand_high),
        .found (hi_found),
        .idx   (hi_idx)
    );

    mirq_prio_pick #(
        .N (`MIRQ_NUM_COUNT)
    ) u_pick_low (
        .req   (cand_low),
        .found (lo_found),
        .idx   (lo_idx)
    );

    // ------------------------------------------------------------------------
    // arbitration against running routines
    // ------------------------------------------------------------------------
    reg        pick_ok;
    reg        pick_high;
    reg [3:0]  pick_num;

    always @* begin
        pick_ok   = 1'b0;
        pick_high = 1'b0;
        pick_num  = 4'h0;
        // a high pick may cut into a low routine, never into a high one
        if (hi_found & ~high_prio_running) begin // [RULE16]
            pick_ok   = 1'b1;
            pick_high = 1'b1;
            pick_num  = hi_idx;
        end else if (lo_found & ~high_prio_running & ~low_prio_running) begin // [RULE16]
            pick_ok   = 1'b1;
            pick_num  = lo_idx;
        end
    end

    // ------------------------------------------------------------------------
    // core request and vector
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            core_irq_req  <= 1'b0;
            core_vec_addr <= 16'h0000;
            core_vec_num  <= 4'h0;
            req_is_high   <= 1'b0;
        end else if (take | core_reti) begin
            // one idle cycle so the new running state is seen
            core_irq_req <= 1'b0;
        end else begin
            core_irq_req  <= pick_ok; // [RULE15]
            core_vec_num  <= pick_num;
            core_vec_addr <= vec_addr(pick_num); // [RULE2] [RULE3]
            req_is_high   <= pick_high;
        end
    end

    // ------------------------------------------------------------------------
    // running routine flags, two-level nesting
    // ------------------------------------------------------------------------
    always @(posedge mclk) begin
        if (srst) begin
            high_prio_running <= 1'b0;
            low_prio_running  <= 1'b0;
        end else if (take) begin
            if (req_is_high) begin
                high_prio_running <= 1'b1; // [RULE16]
            end else begin
                low_prio_running <= 1'b1;
            end
        end else if (core_reti) begin
            // the high routine is the inner one and returns first
            if (high_prio_running) begin
                high_prio_running <= 1'b0;
            end else begin
                low_prio_running <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // event status, read clears, set wins
    // ------------------------------------------------------------------------
    reg [`MIRQ_STAT_BITS-1:0] ev_set;
    reg [`MIRQ_STAT_BITS-1:0] next_status;

    always @* begin
        ev_set = {`MIRQ_STAT_BITS{1'b0}};
        ev_set[`MIRQ_STAT_TAKEN]   = take;
        ev_set[`MIRQ_STAT_PREEMPT] = take & req_is_high & low_prio_running; // [RULE16]
        ev_set[`MIRQ_STAT_PINEVT]  = pin_rise;
        next_status = event_status;
        // clear only what the read handed out; events during the access stay
        if (rd_stb & (reg_idx == `MIRQ_IDX_STAT) & (paddr[1:0] == 2'b00)) begin
            next_status = event_status & ~prdata[`MIRQ_STAT_BITS-1:0];
        end
        next_status = next_status | ev_set;
    end

    always @(posedge mclk) begin
        if (srst) begin
            event_status <= {`MIRQ_STAT_BITS{1'b0}};
            irq_out      <= 1'b0;
        end else begin
            event_status <= next_status;
            irq_out      <= |(next_status & event_mask);
        end
    end

endmodule // mirq_top

/* File: shared/mirq_defines.vh */
// constants of the microcontroller interrupt controller
//
// Overview of operation
// (RULE1) thirteen request sources are taken: six classic ones and seven extended ones.
// (RULE2) classic sources vector to 0x0003 + 8*n for numbers 0 to 5.
// (RULE3) extended sources vector to 0x0033..0x0053 for numbers 6 to 10, gpio to 0x0063 and watchdog to 0x006b.
// (RULE4) number 0 carries external line zero when the led card select is 0 and the led card request when it is 1.
// (RULE5) among equal programmed priority the lowest interrupt number wins, 0 highest, 13 lowest.
// (RULE6) requests are served only while global allow (bit 7) is 1 and global block (bit 6) is 0.
// (RULE7) software sets global block around flash programming or erase to hold off interrupts.
// (RULE8) the basic enable register holds enables for timer2, serial0, timer1, line one, timer0 and line zero.
// (RULE9) the extended enable register holds enables for watchdog, gpio, serial1, converter, usb, timer3 and spi.
// (RULE10) bit 5 of the extended enable register is read-only zero and ignores writes.
// (RULE11) all five interrupt control registers clear to zero on reset, so every source is disabled.
// (RULE12) the gpio source is one combined request built from seven selectable pins.
// (RULE13) the basic priority register shows high and low routine running flags at bits 7 and 6, bits 5..0 writable.
// (RULE14) bit 7 of the extended priority register reads 1 only while exactly one routine is active.
// (RULE15) a request reaches the core only with flag, enable and global gating all set; number 11 is never used.
// (RULE16) a higher-priority request preempts a running low routine; same or lower level waits for return.
`ifndef MIRQ_DEFINES_VH
`define MIRQ_DEFINES_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define MIRQ_IDX_BIE   8'ha8
`define MIRQ_IDX_BPRI  8'hb8
`define MIRQ_IDX_PIE   8'hcf
`define MIRQ_IDX_XIE   8'he8
`define MIRQ_IDX_XPRI  8'he9
`define MIRQ_IDX_CTRL  8'hf0
`define MIRQ_IDX_STAT  8'hf1
`define MIRQ_IDX_MASK  8'hf2

// ----------------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------------
`define MIRQ_RST_REG    8'h00
`define MIRQ_XIE_WMASK  8'hdf
`define MIRQ_GLB_ALLOW  7
`define MIRQ_GLB_BLOCK  6
`define MIRQ_PIE_EDGE   7
`define MIRQ_BPRI_HRUN  7
`define MIRQ_BPRI_LRUN  6
`define MIRQ_XPRI_NEST  7
`define MIRQ_CTRL_LEDSEL 0
`define MIRQ_STAT_TAKEN 0
`define MIRQ_STAT_PREEMPT 1
`define MIRQ_STAT_PINEVT 2
`define MIRQ_STAT_BITS  3

// ----------------------------------------------------------------------------
// vectors
// ----------------------------------------------------------------------------
`define MIRQ_NUM_COUNT  14
`define MIRQ_VEC_BASE   16'h0003
`define MIRQ_NUM_UNUSED 4'hb
`define MIRQ_NUM_GPIO   4'hc

`endif

/* File: verification/mirq_core_model.sv */
// behavioural cpu core that takes vectors and returns from routines
module mirq_core_model (
    input  wire       mclk,
    input  wire       srst,
    input  wire       ack_en,
    input  wire       reti_go,
    input  wire [3:0] lag,
    input  wire       core_irq_req,
    input  wire [3:0] core_vec_num,
    output reg        core_ack,
    output reg        core_reti,
    output reg        taken,
    output reg  [3:0] taken_num
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] waited;

    // acks after lag cycles of standing request, never two edges running
    always @(posedge mclk) begin
        if (srst) begin
            core_ack  <= 1'b0;
            core_reti <= 1'b0;
            taken     <= 1'b0;
            taken_num <= 4'h0;
            waited    <= 4'h0;
        end else begin
            taken     <= core_ack && core_irq_req;
            if (core_ack && core_irq_req) begin
                taken_num <= core_vec_num;
            end
            waited    <= (core_irq_req && !core_ack) ? waited + 4'h1 : 4'h0;
            core_ack  <= ack_en && core_irq_req && !core_ack && waited >= lag;
            core_reti <= reti_go;
        end
    end
endmodule // mirq_core_model

/* File: verification/mirq_top_props.sv */
// concurrent checks on the interrupt controller ports
module mirq_top_props (
    input wire        mclk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        ext_line_zero,
    input wire        led_card_req,
    input wire        timer_zero_req,
    input wire        ext_line_one,
    input wire        timer_one_req,
    input wire        serial_zero_req,
    input wire        timer_two_req,
    input wire        spi_port_req,
    input wire        timer_three_req,
    input wire        usb_link_req,
    input wire        converter_req,
    input wire        serial_one_req,
    input wire        watchdog_req,
    input wire        core_ack,
    input wire        core_reti,
    input wire        core_irq_req,
    input wire [15:0] core_vec_addr,
    input wire [3:0]  core_vec_num,
    input wire        irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [13:0] flags_q;

    // number 12 may stem from a latched pin edge, so it is not traced back
    always @(posedge mclk) begin
        flags_q <= {watchdog_req, 1'b1, 1'b0, serial_one_req, converter_req, usb_link_req, timer_three_req,
                    spi_port_req, timer_two_req, serial_zero_req, timer_one_req, ext_line_one,
                    timer_zero_req, ext_line_zero | led_card_req};
    end

    a_reset_quiet: assert property (@(posedge mclk) srst |=> !core_irq_req && !irq_out && !pready)
        else $error("outputs busy after reset");
    a_apb_one_wait: assert property (@(posedge mclk) disable iff (srst) psel && !penable |=> ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (@(posedge mclk) disable iff (srst) pready |=> !pready)
        else $error("pready longer than one cycle");
    a_refuse_zero: assert property (@(posedge mclk) disable iff (srst) pslverr |-> pready && prdata == 32'h0)
        else $error("refused access returned data");
    a_vec_addr_map: assert property (@(posedge mclk) disable iff (srst)
        core_irq_req |-> core_vec_addr == {9'h000, core_vec_num, 3'h3}) else $error("vector address wrong");
    a_req_has_cause: assert property (@(posedge mclk) disable iff (srst)
        core_irq_req |-> flags_q[core_vec_num]) else $error("request without source flag");
    a_ack_drops_req: assert property (@(posedge mclk) disable iff (srst)
        core_ack && core_irq_req |=> !core_irq_req) else $error("request kept after ack");
    a_reti_gap: assert property (@(posedge mclk) disable iff (srst)
        core_reti && !(core_ack && core_irq_req) |=> !core_irq_req) else $error("request right after return");
endmodule // mirq_top_props

bind mirq_top mirq_top_props i_mirq_top_props (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_line_zero(ext_line_zero), .led_card_req(led_card_req),
    .timer_zero_req(timer_zero_req), .ext_line_one(ext_line_one), .timer_one_req(timer_one_req),
    .serial_zero_req(serial_zero_req), .timer_two_req(timer_two_req), .spi_port_req(spi_port_req),
    .timer_three_req(timer_three_req), .usb_link_req(usb_link_req), .converter_req(converter_req),
    .serial_one_req(serial_one_req), .watchdog_req(watchdog_req), .core_ack(core_ack),
    .core_reti(core_reti), .core_irq_req(core_irq_req), .core_vec_addr(core_vec_addr),
    .core_vec_num(core_vec_num), .irq_out(irq_out)
);

/* File: verification/mirq_top_tb.sv */
// self-checking bench for the interrupt controller
`include "mirq_defines.vh"

module mirq_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [13:0] src;
    logic [6:0]  pins;
    logic        led;
    logic        ack_en;
    logic        reti_go;
    logic [3:0]  lag;
    logic [7:0]  rd;
    logic        err;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         core_ack;
    wire         core_reti;
    wire         core_irq_req;
    wire  [15:0] core_vec_addr;
    wire  [3:0]  core_vec_num;
    wire         irq_out;
    wire         taken;
    wire  [3:0]  taken_num;
    int          n_errors = 0;
    int          n_compared = 0;
    logic [7:0]  regs [5] = '{`MIRQ_IDX_BIE, `MIRQ_IDX_BPRI, `MIRQ_IDX_PIE, `MIRQ_IDX_XIE, `MIRQ_IDX_XPRI};
    logic [7:0]  rmask [5] = '{8'hff, 8'h3f, 8'hff, 8'hdf, 8'h7f};

    always #4 mclk = ~mclk;

    mirq_top i_mirq_top (
        .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_line_zero(src[0]),
        .led_card_req(led), .timer_zero_req(src[1]), .ext_line_one(src[2]), .timer_one_req(src[3]),
        .serial_zero_req(src[4]), .timer_two_req(src[5]), .spi_port_req(src[6]), .timer_three_req(src[7]),
        .usb_link_req(src[8]), .converter_req(src[9]), .serial_one_req(src[10]), .watchdog_req(src[13]),
        .gpio_pins(pins), .core_ack(core_ack), .core_reti(core_reti), .core_irq_req(core_irq_req),
        .core_vec_addr(core_vec_addr), .core_vec_num(core_vec_num), .irq_out(irq_out));

    mirq_core_model i_mirq_core_model (
        .mclk(mclk), .srst(srst), .ack_en(ack_en), .reti_go(reti_go), .lag(lag), .core_irq_req(core_irq_req),
        .core_vec_num(core_vec_num), .core_ack(core_ack), .core_reti(core_reti), .taken(taken),
        .taken_num(taken_num));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            n_errors++;
            end_of_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check($sformatf("register %h", idx), {8'h00, rd}, {8'h00, exp});
    endtask

    task automatic quiet(input string what);
        repeat (5) @(posedge mclk);
        check(what, {15'h0000, core_irq_req}, 16'h0000);
    endtask

    task automatic take(input logic [3:0] num);
        int n;
        ack_en <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (taken !== 1'b1 && n < 60);
        ack_en <= 1'b0;
        if (n == 60) begin
            n_errors++;
            end_of_test();
        end
        check("vector number", {12'h000, taken_num}, {12'h000, num});
    endtask

    task automatic reti();
        reti_go <= 1'b1;
        @(posedge mclk);
        reti_go <= 1'b0;
        @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        src = 14'h0000;
        pins = 7'h00;
        led = 1'b0;
        ack_en = 1'b0;
        reti_go = 1'b0;
        lag = 4'h0;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            rdc(regs[i], 8'h00);
            wreg(regs[i], 8'hff);
            rdc(regs[i], rmask[i]);
            wreg(regs[i], 8'h00);
        end
        apb(1'b0, 8'h10, 8'h00);
        check("unmapped error", {15'h0000, err}, 16'h0001);
        check("unmapped data", {8'h00, rd}, 16'h0000);
        $display("test registers done");
        wreg(`MIRQ_IDX_XIE, 8'hdf);
        wreg(`MIRQ_IDX_PIE, 8'h7f);
        src <= 14'h27ff;
        pins <= 7'h40;
        wreg(`MIRQ_IDX_BIE, 8'hbf);
        for (int k = 0; k < 14; k++) begin
            if (k != 11) begin
                take(k[3:0]);
                if (k < 13) begin
                    quiet("same level held");
                end
                src[k] <= 1'b0;
                pins <= (k == 12) ? 7'h00 : pins;
                reti();
            end
        end
        check("irq masked", {15'h0000, irq_out}, 16'h0000);
        wreg(`MIRQ_IDX_MASK, 8'h01);
        repeat (2) @(posedge mclk);
        check("irq raised", {15'h0000, irq_out}, 16'h0001);
        apb(1'b0, `MIRQ_IDX_STAT, 8'h00);
        check("status taken", {15'h0000, rd[0]}, 16'h0001);
        repeat (2) @(posedge mclk);
        check("irq cleared", {15'h0000, irq_out}, 16'h0000);
        $display("test priority done");
        wreg(`MIRQ_IDX_CTRL, 8'h01);
        src[0] <= 1'b1;
        quiet("line zero deselected");
        led <= 1'b1;
        take(4'h0);
        src[0] <= 1'b0;
        led <= 1'b0;
        reti();
        wreg(`MIRQ_IDX_CTRL, 8'h00);
        wreg(`MIRQ_IDX_BIE, 8'hff);
        src[1] <= 1'b1;
        quiet("blocked");
        wreg(`MIRQ_IDX_BIE, 8'h3f);
        quiet("not allowed");
        wreg(`MIRQ_IDX_BIE, 8'hbd);
        quiet("source disabled");
        wreg(`MIRQ_IDX_BIE, 8'hbf);
        take(4'h1);
        src[1] <= 1'b0;
        reti();
        $display("test gating done");
        lag <= 4'h3;
        wreg(`MIRQ_IDX_BPRI, 8'h20);
        src[3] <= 1'b1;
        take(4'h3);
        src[3] <= 1'b0;
        rdc(`MIRQ_IDX_BPRI, 8'h60);
        rdc(`MIRQ_IDX_XPRI, 8'h80);
        src[5] <= 1'b1;
        take(4'h5);
        src[5] <= 1'b0;
        rdc(`MIRQ_IDX_BPRI, 8'he0);
        rdc(`MIRQ_IDX_XPRI, 8'h00);
        reti();
        reti();
        rdc(`MIRQ_IDX_BPRI, 8'h20);
        wreg(`MIRQ_IDX_PIE, 8'hc0);
        pins <= 7'h40;
        take(4'hc);
        reti();
        quiet("edge served once");
        rdc(`MIRQ_IDX_STAT, 8'h07);
        $display("test nesting done");
        end_of_test();
    end
endmodule // mirq_top_tb
